// ===== logic/rxf_top.sv
// receive acceptance filter, receive status, tallies and tx page start
//
// Behaviour
// [RULE1] errored frames dropped unless saving errored frames
// [RULE2] short frames kept only if enabled, >=8 bytes
// [RULE3] all-ones destination kept only when enabled
// [RULE4] group addresses pass through the hash filter
// [RULE5] station address must match unless any accepted
// [RULE6] check-only mode: no buffering, count missed frames
// [RULE7] address type picks one test: all-ones, else group, else own match
// [RULE8] software: full promiscuous needs all enables, hash ones
// [RULE9] status byte written for good or saved frames
// [RULE10] status cleared when next frame starts
// [RULE11] intact only if no crc, align, overflow, missed
// [RULE12] crc mismatch sets crc flag and tally
// [RULE13] dribble bits plus crc fail: alignment error
// [RULE14] good crc with dribble is no error
// [RULE15] fifo overflow sets flag and aborts frame
// [RULE16] no buffer or check-only sets missed, tally
// [RULE17] group match flag: 0 station, 1 group
// [RULE18] rx off flag follows check-only mode
// [RULE19] defer flag follows carrier or collision
// [RULE20] registers are 8 bits wide, the config register 6
// [RULE21] page registers hold address bits 15-8
// [RULE22] tx start loads page, low byte zero
// [RULE23] six crc msbs pick one of 64 hash bits
// [RULE24] tallies saturate at 192, clear on read
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module rxf_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receive byte path
    input rxf_pkg::rxf_rx_s rx_in,
    input wire logic rx_fifo_ovf,
    input wire logic rx_no_buffer,
    // line state pins
    input wire logic carrier_pin,
    input wire logic collision_pin,
    // buffer memory and transmit dma
    output rxf_pkg::rxf_stat_wr_s stat_wr,
    output logic tx_go,
    output logic [15:0] tx_dma_addr
);
    import rxf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic aw_hold_reg, aw_next, awready_reg;
    logic w_hold_reg, w_next, wready_reg;
    logic [7:0] aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_fire, wr_ok, wr_en;
    logic rvalid_reg, rv_next, arready_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rd_fire, rd_ok;
    logic [7:0] rd_byte;

    logic [CFG_W-1:0] cfg_reg;
    logic [7:0] stat_reg;
    logic [7:0] tx_page_reg, tx_len_lo_reg, tx_len_hi_reg;
    logic [7:0] sta_reg [RXF_N_STA];
    logic [7:0] hash_reg [RXF_N_HASH];
    logic [7:0] tally_reg [RXF_N_TALLY];
    logic [RXF_N_TALLY-1:0] tally_inc, tally_clr;
    logic tx_go_reg;
    logic [15:0] tx_dma_addr_reg;
    rxf_stat_wr_s stat_wr_reg;

    logic cs_meta_reg, cs_sync_reg, col_meta_reg, col_sync_reg;

    rxf_rx_e state_reg;
    logic [15:0] cnt_reg, len;
    logic [7:0] dest_reg [RXF_N_STA];
    logic [31:0] crc_reg, crc_nx;
    logic [5:0] hash_idx_reg;
    logic byte_in, sof_in, eof_in, abort;
    logic is_group, is_ones, phys_hit, hash_hit, addr_ok, len_ok;
    logic crc_bad, align_bad, accept, missed, store;
    logic [7:0] frame_stat;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // one byte through the crc generator, lsb first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[31] ^ d[i];
            r = {r[30:0], 1'b0};
            if (fb) begin
                r = r ^ RXF_CRC_POLY;
            end
        end
        return r;
    endfunction

    // saturating tally step; a read clear with an increment leaves one
    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic inc,
                                           input logic clr);
        if (clr) begin
            return inc ? 8'h01 : 8'h00;
        end
        if (inc && v < RXF_TALLY_MAX) begin
            return v + 8'h01;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_en = wr_fire & wr_ok & w_lane0_reg;

    always_comb begin
        aw_next = aw_hold_reg;
        w_next = w_hold_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_next = 1'b1;
        end else if (wr_fire) begin
            aw_next = 1'b0;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_next = 1'b1;
        end else if (wr_fire) begin
            w_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_addr_reg <= RXF_BYTE_RST;
            w_byte_reg <= RXF_BYTE_RST;
            w_lane0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RXF_OKAY;
        end else begin
            aw_hold_reg <= aw_next;
            w_hold_reg <= w_next;
            awready_reg <= ~aw_next;
            wready_reg <= ~w_next;
            if (s_axi_awvalid && awready_reg) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? RXF_OKAY : RXF_DECERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // writable addresses; the tallies and the status are read-only
    always_comb begin
        wr_ok = (aw_addr_reg == RXF_A_CFG) || (aw_addr_reg == RXF_A_TXPG) ||
                (aw_addr_reg == RXF_A_TXLL) || (aw_addr_reg == RXF_A_TXLH) ||
                (aw_addr_reg == RXF_A_TXGO);
        for (int i = 0; i < RXF_N_STA; i++) begin
            if (aw_addr_reg == 8'(RXF_A_STA + 4 * i)) begin
                wr_ok = 1'b1;
            end
        end
        for (int i = 0; i < RXF_N_HASH; i++) begin
            if (aw_addr_reg == 8'(RXF_A_HASH + 4 * i)) begin
                wr_ok = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    assign rd_fire = s_axi_arvalid & arready_reg;
    assign rv_next = rd_fire | (rvalid_reg & ~s_axi_rready);

    // [RULE20] byte-wide read map
    always_comb begin
        rd_ok = 1'b1;
        rd_byte = 8'h00;
        if (s_axi_araddr == RXF_A_CFG) begin
            rd_byte = stat_reg;
        end else if (s_axi_araddr == RXF_A_TXGO) begin
            rd_byte = tx_dma_addr_reg[15:8];
        end else begin
            rd_ok = 1'b0;
        end
        for (int i = 0; i < RXF_N_TALLY; i++) begin
            tally_clr[i] = rd_fire && (s_axi_araddr == 8'(RXF_A_TALLY + 4 * i));
            if (s_axi_araddr == 8'(RXF_A_TALLY + 4 * i)) begin
                rd_ok = 1'b1;
                rd_byte = tally_reg[i];
            end
        end
        for (int i = 0; i < RXF_N_STA; i++) begin
            if (s_axi_araddr == 8'(RXF_A_STA + 4 * i)) begin
                rd_ok = 1'b1;
                rd_byte = sta_reg[i];
            end
        end
        for (int i = 0; i < RXF_N_HASH; i++) begin
            if (s_axi_araddr == 8'(RXF_A_HASH + 4 * i)) begin
                rd_ok = 1'b1;
                rd_byte = hash_reg[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RXF_OKAY;
        end else begin
            rvalid_reg <= rv_next;
            arready_reg <= ~rv_next;
            if (rd_fire) begin
                rdata_reg <= {24'h000000, rd_byte};
                rresp_reg <= rd_ok ? RXF_OKAY : RXF_DECERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers and transmit start

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= RXF_CFG_RST;
            tx_page_reg <= RXF_BYTE_RST;
            tx_len_lo_reg <= RXF_BYTE_RST;
            tx_len_hi_reg <= RXF_BYTE_RST;
            for (int i = 0; i < RXF_N_STA; i++) begin
                sta_reg[i] <= RXF_BYTE_RST;
            end
            for (int i = 0; i < RXF_N_HASH; i++) begin
                hash_reg[i] <= RXF_BYTE_RST;
            end
        end else if (wr_en) begin
            if (aw_addr_reg == RXF_A_CFG) begin
                cfg_reg <= w_byte_reg[CFG_W-1:0];
            end
            // [RULE21] page holds bits 15-8
            if (aw_addr_reg == RXF_A_TXPG) begin
                tx_page_reg <= w_byte_reg;
            end
            // [RULE20] 16-bit length split
            if (aw_addr_reg == RXF_A_TXLL) begin
                tx_len_lo_reg <= w_byte_reg;
            end
            if (aw_addr_reg == RXF_A_TXLH) begin
                tx_len_hi_reg <= w_byte_reg;
            end
            for (int i = 0; i < RXF_N_STA; i++) begin
                if (aw_addr_reg == 8'(RXF_A_STA + 4 * i)) begin
                    sta_reg[i] <= w_byte_reg;
                end
            end
            for (int i = 0; i < RXF_N_HASH; i++) begin
                if (aw_addr_reg == 8'(RXF_A_HASH + 4 * i)) begin
                    hash_reg[i] <= w_byte_reg;
                end
            end
        end
    end

    // [RULE22] start loads page address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_go_reg <= 1'b0;
            tx_dma_addr_reg <= 16'h0000;
        end else begin
            tx_go_reg <= wr_en && (aw_addr_reg == RXF_A_TXGO) && w_byte_reg[0];
            if (wr_en && (aw_addr_reg == RXF_A_TXGO) && w_byte_reg[0]) begin
                tx_dma_addr_reg <= {tx_page_reg, 8'h00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // line state synchronisers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_meta_reg <= 1'b0;
            cs_sync_reg <= 1'b0;
            col_meta_reg <= 1'b0;
            col_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg <= carrier_pin;
            cs_sync_reg <= cs_meta_reg;
            col_meta_reg <= collision_pin;
            col_sync_reg <= col_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame evaluation

    assign byte_in = rx_in.valid;
    assign sof_in = byte_in & rx_in.sof;
    assign eof_in = byte_in & rx_in.eof & (state_reg != RX_IDLE | rx_in.sof);
    assign abort = rx_fifo_ovf & (state_reg != RX_IDLE);
    assign crc_nx = crc_byte(sof_in ? RXF_CRC_INIT : crc_reg, rx_in.data);

    always_comb begin
        len = sof_in ? 16'h0001 : cnt_reg + 16'h0001;
        is_group = dest_reg[0][0];
        is_ones = 1'b1;
        phys_hit = 1'b1;
        for (int i = 0; i < RXF_N_STA; i++) begin
            is_ones = is_ones & (&dest_reg[i]);
            phys_hit = phys_hit & (dest_reg[i] == sta_reg[i]);
        end
        // [RULE23] hash bit lookup
        hash_hit = hash_reg[hash_idx_reg[5:3]][hash_idx_reg[2:0]];
        // [RULE3] [RULE4] [RULE5] [RULE7] address filter
        addr_ok = is_ones ? cfg_reg[CFG_ONES] :
                  is_group ? (cfg_reg[CFG_GROUP] & hash_hit) :
                  (cfg_reg[CFG_ANY] | phys_hit);
        // [RULE2] length filter
        len_ok = (len >= RXF_MIN_LEN) || (cfg_reg[CFG_SHORT] && len >= RXF_RUNT_MIN);
        // [RULE12] [RULE13] [RULE14] error coding
        crc_bad = ~rx_in.crc_ok;
        align_bad = crc_bad & (rx_in.dribble != 3'h0);
        // [RULE1] errored frame handling
        accept = addr_ok & len_ok & (~crc_bad | cfg_reg[CFG_SAVE_ERR]);
        // [RULE6] [RULE16] missed frame
        missed = accept & (cfg_reg[CFG_CHECK_ONLY] | rx_no_buffer);
        store = accept & ~missed;
        // [RULE11] [RULE17] frame status
        frame_stat = 8'h00;
        frame_stat[ST_INTACT] = ~crc_bad & ~missed;
        frame_stat[ST_CRC] = crc_bad;
        frame_stat[ST_ALIGN] = align_bad;
        frame_stat[ST_MISSED] = missed;
        frame_stat[ST_GROUP] = is_group;
        tally_inc = 3'h0;
        if (eof_in && !abort && addr_ok && len_ok) begin
            tally_inc[TL_ALIGN] = align_bad;
            tally_inc[TL_CRC] = crc_bad;
            tally_inc[TL_MISS] = missed;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RX_IDLE;
            cnt_reg <= 16'h0000;
            crc_reg <= RXF_CRC_INIT;
            hash_idx_reg <= 6'h00;
            for (int i = 0; i < RXF_N_STA; i++) begin
                dest_reg[i] <= RXF_BYTE_RST;
            end
        end else if (abort) begin
            state_reg <= RX_IDLE;
        end else if (byte_in && (sof_in || state_reg != RX_IDLE)) begin
            cnt_reg <= len;
            crc_reg <= crc_nx;
            if (state_reg == RX_ADDR || sof_in) begin
                dest_reg[len[2:0] - 3'h1] <= rx_in.data;
            end
            // [RULE23] latch six crc msbs
            if (len == RXF_DEST_LAST + 16'h0001) begin
                hash_idx_reg <= crc_nx[31:26];
            end
            case (state_reg)
                RX_IDLE: state_reg <= RX_ADDR;
                RX_ADDR: state_reg <= (len > RXF_DEST_LAST) ? RX_DATA : RX_ADDR;
                RX_DATA: state_reg <= RX_DATA;
                default: state_reg <= RX_IDLE;
            endcase
            if (eof_in) begin
                state_reg <= RX_IDLE;
            end
        end
    end

    // status register and status write to buffer memory
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= RXF_BYTE_RST;
            stat_wr_reg <= '0;
        end else begin
            // [RULE18] rx off follows mode
            stat_reg[ST_OFF] <= cfg_reg[CFG_CHECK_ONLY];
            // [RULE19] defer from line state
            stat_reg[ST_DEFER] <= cs_sync_reg | col_sync_reg;
            stat_wr_reg.valid <= 1'b0;
            if (abort) begin
                // [RULE15] overflow aborts frame
                stat_reg[ST_OVF] <= 1'b1;
                stat_reg[ST_INTACT] <= 1'b0;
            end else if (eof_in && addr_ok && len_ok) begin
                stat_reg[5:0] <= frame_stat[5:0];
                // [RULE9] write status when buffered
                stat_wr_reg.valid <= store;
                stat_wr_reg.status <= {cs_sync_reg | col_sync_reg,
                                       cfg_reg[CFG_CHECK_ONLY], frame_stat[5:0]};
            end else if (sof_in) begin
                // [RULE10] clear on frame start
                stat_reg[5:0] <= 6'h00;
            end
        end
    end

    // [RULE24] saturating read-clear tallies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < RXF_N_TALLY; i++) begin
                tally_reg[i] <= RXF_BYTE_RST;
            end
        end else begin
            for (int i = 0; i < RXF_N_TALLY; i++) begin
                tally_reg[i] <= sat_inc(tally_reg[i], tally_inc[i], tally_clr[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign stat_wr = stat_wr_reg;
    assign tx_go = tx_go_reg;
    assign tx_dma_addr = tx_dma_addr_reg;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_frame_end;
        eof_in && !abort;
    endsequence

    property p_err_drop;
        s_frame_end and (crc_bad && !cfg_reg[CFG_SAVE_ERR]) |=> !stat_wr_reg.valid;
    endproperty
    a_err_drop: assert property (p_err_drop) else $error("errored frame stored"); // [RULE1]

    property p_runt;
        s_frame_end and (len < RXF_RUNT_MIN) |=> !stat_wr_reg.valid;
    endproperty
    a_runt: assert property (p_runt) else $error("tiny frame stored"); // [RULE2]

    property p_ones;
        s_frame_end and (is_ones && !cfg_reg[CFG_ONES]) |=> !stat_wr_reg.valid;
    endproperty
    a_ones: assert property (p_ones) else $error("all-ones frame stored"); // [RULE3]

    property p_check_only;
        s_frame_end and cfg_reg[CFG_CHECK_ONLY] |=> !stat_wr_reg.valid;
    endproperty
    a_check_only: assert property (p_check_only) else $error("frame buffered in check mode"); // [RULE6]

    property p_intact;
        stat_wr_reg.valid |-> stat_wr_reg.status[ST_INTACT] ==
            !(stat_wr_reg.status[ST_CRC] || stat_wr_reg.status[ST_MISSED]);
    endproperty
    a_intact: assert property (p_intact) else $error("intact flag wrong"); // [RULE11]

    property p_align;
        !(stat_reg[ST_ALIGN] && !stat_reg[ST_CRC]);
    endproperty
    a_align: assert property (p_align) else $error("alignment without crc"); // [RULE14]

    property p_clear;
        sof_in && !rx_in.eof && !abort |=> stat_reg[5:0] == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared"); // [RULE10]

    sequence s_mode_on;
        cfg_reg[CFG_CHECK_ONLY] ##1 cfg_reg[CFG_CHECK_ONLY];
    endsequence

    property p_rx_off;
        s_mode_on |-> stat_reg[ST_OFF];
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx off flag missing"); // [RULE18]

    property p_tally;
        tally_reg[TL_CRC] <= RXF_TALLY_MAX;
    endproperty
    a_tally: assert property (p_tally) else $error("tally above limit"); // [RULE24]

    property p_tx_page;
        tx_go_reg |-> tx_dma_addr_reg == {tx_page_reg, 8'h00};
    endproperty
    a_tx_page: assert property (p_tx_page) else $error("tx address wrong"); // [RULE22]

endmodule // rxf_top

// ===== logic/rxf_pkg.sv
// shared constants, types and register map of the receive filter block
package rxf_pkg;

    // register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] RXF_A_CFG = 8'h0C;
    localparam logic [7:0] RXF_A_TXPG = 8'h10;
    localparam logic [7:0] RXF_A_TXLL = 8'h14;
    localparam logic [7:0] RXF_A_TXLH = 8'h18;
    localparam logic [7:0] RXF_A_TXGO = 8'h1C;
    localparam logic [7:0] RXF_A_TALLY = 8'h20;
    localparam logic [7:0] RXF_A_STA = 8'h30;
    localparam logic [7:0] RXF_A_HASH = 8'h50;
    localparam int RXF_N_TALLY = 3;
    localparam int RXF_N_STA = 6;
    localparam int RXF_N_HASH = 8;

    // tally order: alignment, crc, missed
    localparam int TL_ALIGN = 0;
    localparam int TL_CRC = 1;
    localparam int TL_MISS = 2;

    // rx_accept_config fields
    localparam int CFG_SAVE_ERR = 0;
    localparam int CFG_SHORT = 1;
    localparam int CFG_ONES = 2;
    localparam int CFG_GROUP = 3;
    localparam int CFG_ANY = 4;
    localparam int CFG_CHECK_ONLY = 5;
    localparam int CFG_W = 6;

    // rx_frame_status fields
    localparam int ST_INTACT = 0;
    localparam int ST_CRC = 1;
    localparam int ST_ALIGN = 2;
    localparam int ST_OVF = 3;
    localparam int ST_MISSED = 4;
    localparam int ST_GROUP = 5;
    localparam int ST_OFF = 6;
    localparam int ST_DEFER = 7;

    // reset values
    localparam logic [CFG_W-1:0] RXF_CFG_RST = 6'h00;
    localparam logic [7:0] RXF_BYTE_RST = 8'h00;

    // frame limits and counters
    localparam logic [15:0] RXF_MIN_LEN = 16'h0040;
    localparam logic [15:0] RXF_RUNT_MIN = 16'h0008;
    localparam logic [15:0] RXF_DEST_LAST = 16'h0005;
    localparam logic [7:0] RXF_TALLY_MAX = 8'hC0;
    localparam logic [31:0] RXF_CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] RXF_CRC_INIT = 32'hFFFFFFFF;

    // bus responses
    localparam logic [1:0] RXF_OKAY = 2'h0;
    localparam logic [1:0] RXF_DECERR = 2'h3;

    typedef enum logic [1:0] {RX_IDLE, RX_ADDR, RX_DATA} rxf_rx_e;

    // one received byte from the decoder path
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
        logic crc_ok;
        logic [2:0] dribble;
    } rxf_rx_s;

    // status byte written into buffer memory
    typedef struct packed {
        logic valid;
        logic [7:0] status;
    } rxf_stat_wr_s;

endpackage

// ===== bench/rxf_frame_src.sv
// frame source standing in for the decoder path
`timescale 1ns/100ps
module rxf_frame_src (
    // clock
    input wire logic aclk,
    // receive byte path
    output rxf_pkg::rxf_rx_s rx_in,
    output logic rx_fifo_ovf
);
    import rxf_pkg::*;
    initial begin
        rx_in = '0;
        rx_fifo_ovf = 1'b0;
    end
    // dest byte six times, then a count; f = {crc ok, no buffer, overflow, stored}
    task automatic send(input logic [7:0] d, input logic [7:0] n, input logic [3:0] f,
                        input logic [2:0] dr);
        for (int i = 0; i < int'(n); i++) begin
            @(posedge aclk);
            rx_in <= '{1'b1, i == 0, i == int'(n) - 1, (i < 6) ? d : 8'(i), f[3], dr};
            rx_fifo_ovf <= f[1] && i == 10;
        end
        @(posedge aclk);
        // idle line shows the inverse of the last byte, not a stale copy
        rx_in <= '{1'b0, 1'b0, 1'b0, ~rx_in.data, 1'b1, 3'h0};
        rx_fifo_ovf <= 1'b0;
    endtask
endmodule // rxf_frame_src

// ===== bench/tb_top.sv
// self-checking bench of the receive filter block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
    import rxf_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] d;
        logic [7:0] n;
        logic [2:0] dr;
        logic [3:0] f;
        logic [7:0] st;
    } rxf_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_no_buffer = 1'b0;
    logic carrier_pin = 1'b0, collision_pin = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_go, rx_fifo_ovf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [15:0] tx_dma_addr, txa;
    logic [7:0] wst;
    rxf_rx_s rx_in;
    rxf_stat_wr_s stat_wr;
    int fail_count = 0, total_checks = 0, cyc = 0, wr_cnt = 0, n0;
    logic [7:0] tl [3] = '{8'h01, 8'h03, 8'h02};
    rxf_row_s rows [16];

    rxf_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in, .rx_fifo_ovf,
        .rx_no_buffer, .carrier_pin, .collision_pin, .stat_wr, .tx_go, .tx_dma_addr);
    rxf_frame_src src_u (.aclk, .rx_in, .rx_fifo_ovf);

    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (stat_wr.valid === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wst <= stat_wr.status;
        end
        if (tx_go === 1'b1) txa <= tx_dma_addr;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{8'h00, 8'h02, 8'h40, 3'h0, 4'h9, 8'h01}, '{8'h00, 8'h06, 8'h40, 3'h0, 4'h8, 8'h00},
            '{8'h10, 8'h06, 8'h40, 3'h0, 4'h9, 8'h01}, '{8'h00, 8'hFF, 8'h40, 3'h0, 4'h8, 8'h00},
            '{8'h04, 8'hFF, 8'h40, 3'h0, 4'h9, 8'h21}, '{8'h08, 8'h03, 8'h40, 3'h0, 4'h9, 8'h21},
            '{8'h00, 8'h02, 8'h3F, 3'h0, 4'h8, 8'h00}, '{8'h02, 8'h02, 8'h08, 3'h0, 4'h9, 8'h01},
            '{8'h02, 8'h02, 8'h07, 3'h0, 4'h8, 8'h00}, '{8'h00, 8'h02, 8'h40, 3'h0, 4'h0, 8'h02},
            '{8'h01, 8'h02, 8'h40, 3'h0, 4'h1, 8'h02}, '{8'h01, 8'h02, 8'h40, 3'h3, 4'h1, 8'h06},
            '{8'h00, 8'h02, 8'h40, 3'h3, 4'h9, 8'h01}, '{8'h20, 8'h02, 8'h40, 3'h0, 4'h8, 8'h50},
            '{8'h00, 8'h02, 8'h40, 3'h0, 4'hC, 8'h10}, '{8'h00, 8'h02, 8'h40, 3'h0, 4'hA, 8'h08}};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(RXF_A_CFG);
        `CHK("status", 32'h0, rd)
        axi_rd(8'h48);
        `CHK("rresp", RXF_DECERR, rsp)
        axi_wr(RXF_A_TALLY, 8'h05);
        `CHK("bresp", RXF_DECERR, rsp)
        for (int i = 0; i < RXF_N_STA; i++) axi_wr(RXF_A_STA + 8'(4 * i), 8'h02);
        for (int i = 0; i < RXF_N_HASH; i++) axi_wr(RXF_A_HASH + 8'(4 * i), 8'hFF);
        foreach (rows[i]) begin
            axi_wr(RXF_A_CFG, rows[i].cfg);
            rx_no_buffer <= rows[i].f[2];
            n0 = wr_cnt;
            src_u.send(rows[i].d, rows[i].n, rows[i].f, rows[i].dr);
            repeat (3) @(posedge aclk);
            `CHK("stored", 32'(rows[i].f[0]), wr_cnt - n0)
            if (rows[i].f[0]) `CHK("status word", rows[i].st, wst)
            axi_rd(RXF_A_CFG);
            `CHK("status", {24'h0, rows[i].st}, rd)
        end
        for (int j = 0; j < RXF_N_TALLY; j++) begin
            axi_rd(RXF_A_TALLY + 8'(4 * j));
            `CHK("tally", {24'h0, tl[j]}, rd)
            axi_rd(RXF_A_TALLY + 8'(4 * j));
            `CHK("tally cleared", 32'h0, rd)
        end
        axi_wr(RXF_A_TXPG, 8'hAB);
        axi_wr(RXF_A_TXGO, 8'h01);
        repeat (2) @(posedge aclk);
        `CHK("tx addr", 16'hAB00, txa)
        axi_rd(RXF_A_TXGO);
        `CHK("tx page", 32'hAB, rd)
        carrier_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(RXF_A_CFG);
        `CHK("defer", 32'h88, rd)
        end_sim();
    end
endmodule // tb_top
